// [logic/rsr_regulator_setting_regs.v]
// Register bank holding converter-2 target/ramp, spread-spectrum control
// and the two linear regulator voltage codes, with decoded settings.
// Assumes a serial interface block delivers decoded byte reads/writes on
// i_sys_clk, and factory defaults arrive as stable straps during reset.
// Summary of operation
// - Converter-2 code: 0 external, 1..0x19 is 1.0-3.5 V skipping 2.3 V.
// - Ramp code 0 instant, 1..10 mV/us, 11..15 act as ten.
// - Spread enable in bit 0 of function register, resets to zero.
// - Triangular sweep about 2 MHz; select 0 is 10 kHz, 1 is 2 kHz.
// - Linear regulator 1: code 0 is 1.0 V, 0.1 V steps, saturates 3.5 V.
// - Linear regulator 2: same decode, codes above 0x19 give 3.5 V.
`timescale 1ns/10ps
`include "rsr_defines.vh"

module rsr_regulator_setting_regs (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst,
  // Register access from serial interface
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata,
  output reg         o_rd_valid,
  // Factory defaults
  input  wire [4:0]  i_dflt_conv2_b,
  input  wire [4:0]  i_dflt_linreg1,
  input  wire [4:0]  i_dflt_linreg2,
  // Converter 2 settings
  output reg         o_conv2_ext_ctrl,
  output reg  [11:0] o_conv2_target_mv,
  output reg  [4:0]  o_conv2_target_code_b,
  output reg  [3:0]  o_conv2_ramp_code,
  output reg         o_conv2_ramp_instant,
  output reg  [3:0]  o_conv2_ramp_mv_per_us,
  // Spread spectrum
  output reg         o_spread_enable,
  output reg         o_spread_mod_rate_sel,
  output reg  [11:0] o_spread_center_khz,
  output reg  [11:0] o_spread_mod_khz,
  // Linear regulators
  output reg  [4:0]  o_linreg1_voltage_code,
  output reg  [11:0] o_linreg1_mv,
  output reg  [4:0]  o_linreg2_voltage_code,
  output reg  [11:0] o_linreg2_mv
);

  reg  [4:0]  conv2_code;
  reg  [3:0]  ramp_code;
  reg         spread_en;
  reg         spread_mod;
  reg  [4:0]  lin1_code;
  reg  [4:0]  lin2_code;
  reg         dflt_pending;
  reg  [7:0]  next_rdata;
  reg  [11:0] next_conv2_mv;
  reg  [3:0]  next_ramp_rate;

  // Reset images of the two whole-byte registers; reserved bits read these
  localparam [7:0] RST_RAMP_BYTE   = `RSR_RST_RAMP;
  localparam [7:0] RST_SPREAD_BYTE = `RSR_RST_SPREAD;

  // Per-register write strobes; writes in the strap load cycle are dropped
  wire        wr_live;
  wire        wr_conv2;
  wire        wr_ramp;
  wire        wr_spread;
  wire        wr_lin1;
  wire        wr_lin2;

  assign wr_live   = i_wr_en && !dflt_pending;
  assign wr_conv2  = wr_live && (i_addr == `RSR_ADDR_CONV2_TGT_B);
  assign wr_ramp   = wr_live && (i_addr == `RSR_ADDR_CONV2_RAMP);
  assign wr_spread = wr_live && (i_addr == `RSR_ADDR_SPREAD_CTRL);
  assign wr_lin1   = wr_live && (i_addr == `RSR_ADDR_LINREG1);
  assign wr_lin2   = wr_live && (i_addr == `RSR_ADDR_LINREG2);

  // Linear decode, 1.0 V at code zero, clamped at 3.5 V
  function [11:0] lin_mv;
    input [4:0] code;
    reg   [11:0] prod;
    begin
      prod = {7'h00, code} * `RSR_MV_STEP;
      if (code > `RSR_VCODE_MAX) begin
        lin_mv = `RSR_MV_TOP;
      end else begin
        lin_mv = `RSR_MV_BASE + prod;
      end
    end
  endfunction

  // Converter-2 decode; codes past the skip move up one extra step
  always @* begin
    next_conv2_mv = `RSR_MV_TOP;
    if (conv2_code == `RSR_VCODE_EXT) begin
      next_conv2_mv = 12'h000;
    end else if (conv2_code < `RSR_VCODE_SKIP) begin
      next_conv2_mv = lin_mv(conv2_code - 5'h01);
    end else if (conv2_code <= `RSR_VCODE_MAX) begin
      next_conv2_mv = lin_mv(conv2_code);
    end
  end

  always @* begin
    if (ramp_code > `RSR_RAMP_MAX) begin
      next_ramp_rate = `RSR_RAMP_MAX;
    end else begin
      next_ramp_rate = ramp_code;
    end
  end

  // Read mux; reserved bits return their reset pattern, unmapped read zero
  always @* begin
    case (i_addr)
      `RSR_ADDR_CONV2_TGT_B: next_rdata = {3'h0, conv2_code};
      `RSR_ADDR_CONV2_RAMP:  next_rdata = {RST_RAMP_BYTE[7:4], ramp_code};
      `RSR_ADDR_SPREAD_CTRL: next_rdata = {RST_SPREAD_BYTE[7:2], spread_mod,
                                           spread_en};
      `RSR_ADDR_LINREG1:     next_rdata = {3'h0, lin1_code};
      `RSR_ADDR_LINREG2:     next_rdata = {3'h0, lin2_code};
      default:               next_rdata = 8'h00;
    endcase
  end

  // Straps cannot be sampled under async reset, so load on first edge
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      dflt_pending <= 1'b1;
    end else begin
      dflt_pending <= 1'b0;
    end
  end

  // Voltage codes: strap default first, then host writes of bits 4:0 only
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      conv2_code <= 5'h00;
      lin1_code  <= 5'h00;
      lin2_code  <= 5'h00;
    end else if (dflt_pending) begin
      conv2_code <= i_dflt_conv2_b;
      lin1_code  <= i_dflt_linreg1;
      lin2_code  <= i_dflt_linreg2;
    end else begin
      if (wr_conv2) begin
        conv2_code <= i_wdata[`RSR_VCODE_MSB:0];
      end
      if (wr_lin1) begin
        lin1_code <= i_wdata[`RSR_VCODE_MSB:0];
      end
      if (wr_lin2) begin
        lin2_code <= i_wdata[`RSR_VCODE_MSB:0];
      end
    end
  end

  // Ramp code: the upper nibble is reserved and never stored
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ramp_code <= RST_RAMP_BYTE[`RSR_RAMP_MSB:0];
    end else if (wr_ramp) begin
      ramp_code <= i_wdata[`RSR_RAMP_MSB:0];
    end
  end

  // Spread control: only the two low bits are writable
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      spread_en  <= RST_SPREAD_BYTE[`RSR_SPREAD_EN_BIT];
      spread_mod <= RST_SPREAD_BYTE[`RSR_SPREAD_MOD_BIT];
    end else if (wr_spread) begin
      spread_en  <= i_wdata[`RSR_SPREAD_EN_BIT];
      spread_mod <= i_wdata[`RSR_SPREAD_MOD_BIT];
    end
  end

  // Read data holds until the next read; valid follows the read strobe one cycle later
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata    <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rdata <= next_rdata;
      end
    end
  end

  // Converter 2 outputs; code and decode move on the same edge
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_conv2_ext_ctrl       <= 1'b1;
      o_conv2_target_mv      <= 12'h000;
      o_conv2_target_code_b  <= 5'h00;
      o_conv2_ramp_code      <= RST_RAMP_BYTE[`RSR_RAMP_MSB:0];
      o_conv2_ramp_instant   <= 1'b0;
      o_conv2_ramp_mv_per_us <= RST_RAMP_BYTE[`RSR_RAMP_MSB:0];
    end else begin
      o_conv2_ext_ctrl       <= (conv2_code == `RSR_VCODE_EXT);
      o_conv2_target_mv      <= next_conv2_mv;
      o_conv2_target_code_b  <= conv2_code;
      o_conv2_ramp_code      <= ramp_code;
      o_conv2_ramp_instant   <= (ramp_code == 4'h0);
      o_conv2_ramp_mv_per_us <= next_ramp_rate;
    end
  end

  // Spread spectrum outputs; centre frequency is fixed
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_spread_enable       <= RST_SPREAD_BYTE[`RSR_SPREAD_EN_BIT];
      o_spread_mod_rate_sel <= RST_SPREAD_BYTE[`RSR_SPREAD_MOD_BIT];
      o_spread_center_khz   <= `RSR_SW_FREQ_KHZ;
      o_spread_mod_khz      <= `RSR_MOD_SLOW_KHZ;
    end else begin
      o_spread_enable       <= spread_en;
      o_spread_mod_rate_sel <= spread_mod;
      o_spread_center_khz   <= `RSR_SW_FREQ_KHZ;
      o_spread_mod_khz      <= spread_mod ? `RSR_MOD_SLOW_KHZ :
                                            `RSR_MOD_FAST_KHZ;
    end
  end

  // Linear regulator outputs
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_linreg1_voltage_code <= 5'h00;
      o_linreg1_mv           <= `RSR_MV_BASE;
      o_linreg2_voltage_code <= 5'h00;
      o_linreg2_mv           <= `RSR_MV_BASE;
    end else begin
      o_linreg1_voltage_code <= lin1_code;
      o_linreg1_mv           <= lin_mv(lin1_code);
      o_linreg2_voltage_code <= lin2_code;
      o_linreg2_mv           <= lin_mv(lin2_code);
    end
  end

endmodule

// [logic/rsr_defines.vh]
// Offsets, field positions, reset values and timing for the regulator
// setting register bank. Included by the bank module only.
`ifndef RSR_DEFINES_VH
`define RSR_DEFINES_VH

// Register offsets
`define RSR_ADDR_CONV2_TGT_B    8'h2a
`define RSR_ADDR_CONV2_RAMP     8'h2b
`define RSR_ADDR_SPREAD_CTRL    8'h38
`define RSR_ADDR_LINREG1        8'h39
`define RSR_ADDR_LINREG2        8'h3a

// Field positions
`define RSR_VCODE_MSB           4
`define RSR_RAMP_MSB            3
`define RSR_SPREAD_EN_BIT       0
`define RSR_SPREAD_MOD_BIT      1

// Reset values of whole registers
`define RSR_RST_RAMP            8'h28
`define RSR_RST_SPREAD          8'h0a

// Voltage and ramp code limits
`define RSR_VCODE_EXT           5'h00
`define RSR_VCODE_MAX           5'h19
`define RSR_VCODE_SKIP          5'h0e
`define RSR_RAMP_MAX            4'ha

// Output voltage in mV: base, 100 mV step and 3.5 V top
`define RSR_MV_BASE             12'h3e8
`define RSR_MV_STEP             12'h064
`define RSR_MV_TOP              12'hdac

// Switching clock figures in kHz
`define RSR_SW_FREQ_KHZ         12'h7d0
`define RSR_MOD_FAST_KHZ        12'h00a
`define RSR_MOD_SLOW_KHZ        12'h002

`endif

// [tb/rsr_monitor.sv]
// Assertions on the regulator setting bank ports.
// Assumes decoded outputs and code outputs update on the same edge.
`timescale 1ns/10ps
module rsr_monitor (
  input wire logic        i_sys_clk, i_rst, i_wr_en, i_rd_en, o_rd_valid,
  input wire logic [7:0]  i_addr, i_wdata,
  input wire logic        o_conv2_ext_ctrl, o_conv2_ramp_instant,
  input wire logic        o_spread_enable, o_spread_mod_rate_sel,
  input wire logic [4:0]  o_conv2_target_code_b, o_linreg1_voltage_code,
  input wire logic [4:0]  o_linreg2_voltage_code,
  input wire logic [3:0]  o_conv2_ramp_code, o_conv2_ramp_mv_per_us,
  input wire logic [11:0] o_conv2_target_mv, o_spread_mod_khz,
  input wire logic [11:0] o_spread_center_khz, o_linreg1_mv, o_linreg2_mv
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  function automatic logic [11:0] lmv(logic [4:0] c);
    return c > 5'h19 ? 12'hdac : 12'h3e8 + 12'h064 * c;
  endfunction
  // Converter code skips 2.3 V, so low codes sit one step lower
  function automatic logic [11:0] cmv(logic [4:0] c);
    return c == 5'h00 ? 12'h000 : c < 5'h0e ? lmv(c) - 12'h064 : lmv(c);
  endfunction
  sequence s_w38; i_wr_en && i_addr == 8'h38; endsequence
  sequence s_w2a; i_wr_en && i_addr == 8'h2a; endsequence
  property p_rv; i_rd_en |=> o_rd_valid; endproperty
  property p_c2; !$past(i_rst) |-> o_conv2_target_mv ==
    cmv(o_conv2_target_code_b) &&
    o_conv2_ext_ctrl == (o_conv2_target_code_b == 5'h00); endproperty
  property p_rmp; !$past(i_rst) |-> o_conv2_ramp_mv_per_us ==
    (o_conv2_ramp_code > 4'ha ? 4'ha : o_conv2_ramp_code) &&
    o_conv2_ramp_instant == (o_conv2_ramp_code == 4'h0); endproperty
  property p_se; s_w38 |=> ##1 o_spread_enable == $past(i_wdata[0], 2);
  endproperty
  property p_mod; !$past(i_rst) |-> o_spread_center_khz == 12'h7d0 &&
    o_spread_mod_khz == (o_spread_mod_rate_sel ? 12'h002 : 12'h00a);
  endproperty
  property p_l1; !$past(i_rst) |->
    o_linreg1_mv == lmv(o_linreg1_voltage_code); endproperty
  property p_l2; !$past(i_rst) |->
    o_linreg2_mv == lmv(o_linreg2_voltage_code); endproperty
  property p_cw; s_w2a |=> ##1
    o_conv2_target_code_b == $past(i_wdata[4:0], 2); endproperty
  a_rv: assert property (p_rv) else $error("read valid late");
  a_c2: assert property (p_c2) else $error("conv2 decode");
  a_rmp: assert property (p_rmp) else $error("ramp decode");
  a_se: assert property (p_se) else $error("spread enable");
  a_mod: assert property (p_mod) else $error("mod rate");
  a_l1: assert property (p_l1) else $error("linreg1 decode");
  a_l2: assert property (p_l2) else $error("linreg2 decode");
  a_cw: assert property (p_cw) else $error("conv2 code store");
endmodule
bind rsr_regulator_setting_regs rsr_monitor mon (.*);

// [tb/rsr_host.sv]
// Host side of the byte register access.
// Assumes fixed one-clock read latency.
`timescale 1ns/10ps
module rsr_host (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en = 1'b0,
  output logic            o_rd_en = 1'b0,
  output logic [7:0]      o_addr = 8'h00,
  output logic [7:0]      o_wdata = 8'h00
);
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_sys_clk) o_wr_en <= 1'b0;
  endtask
  // Missing valid yields unknown so the caller's compare fails
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk) o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk) o_rd_en <= 1'b0;
    @(posedge i_sys_clk) d = i_rd_valid === 1'b1 ? i_rdata : 8'hxx;
  endtask
endmodule

// [tb/tb_rsr_regulator_setting_regs.sv]
// Register bank bench: reset values, masking, decode.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module tb_rsr_regulator_setting_regs;
  logic clk = 1'b0, rst = 1'b1;
  wire we, re, rv, ext, ri, se, ss;
  wire [7:0] a, wd, rdat;
  wire [11:0] cmv, ck, mk, l1m, l2m;
  wire [4:0] cc, l1c, l2c;
  wire [3:0] rc, rm;
  int error_cnt = 0, checks = 0;
  logic [7:0] d;
  logic [7:0] t [9][3] = '{'{8'h2a,8'hff,8'h1f}, '{8'h2a,8'h0e,8'h0e},
    '{8'h2a,8'h00,8'h00}, '{8'h2b,8'hff,8'h2f}, '{8'h2b,8'h00,8'h20},
    '{8'h38,8'hfd,8'h09}, '{8'h39,8'h1a,8'h1a}, '{8'h3a,8'hff,8'h1f},
    '{8'h44,8'hff,8'h00}};
  always #5 clk = ~clk;
  rsr_regulator_setting_regs dut (.i_sys_clk(clk), .i_rst(rst),
    .i_wr_en(we), .i_rd_en(re), .i_addr(a), .i_wdata(wd), .o_rdata(rdat),
    .o_rd_valid(rv), .i_dflt_conv2_b(5'h17), .i_dflt_linreg1(5'h19),
    .i_dflt_linreg2(5'h08), .o_conv2_ext_ctrl(ext), .o_conv2_target_mv(cmv),
    .o_conv2_target_code_b(cc), .o_conv2_ramp_code(rc),
    .o_conv2_ramp_instant(ri), .o_conv2_ramp_mv_per_us(rm),
    .o_spread_enable(se), .o_spread_mod_rate_sel(ss),
    .o_spread_center_khz(ck), .o_spread_mod_khz(mk),
    .o_linreg1_voltage_code(l1c), .o_linreg1_mv(l1m),
    .o_linreg2_voltage_code(l2c), .o_linreg2_mv(l2m));
  rsr_host h (.i_sys_clk(clk), .i_rd_valid(rv), .i_rdata(rdat),
    .o_wr_en(we), .o_rd_en(re), .o_addr(a), .o_wdata(wd));
  task chk(input string n, input logic [11:0] e, input logic [11:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task rchk(input logic [7:0] ad, input logic [7:0] e);
    h.rd(ad, d);
    chk("rdata", {4'h0, e}, {4'h0, d});
  endtask
  // Decoded outputs move one edge after the write strobe is taken
  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task conclude;
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(8'h2a, 8'h17);
    rchk(8'h2b, 8'h28);
    rchk(8'h38, 8'h0a);
    rchk(8'h39, 8'h19);
    rchk(8'h3a, 8'h08);
    rchk(8'h40, 8'h00);
    chk("mod khz", 12'h002, mk);
    chk("linreg2 mv", 12'h708, l2m);
    for (int i = 0; i < 9; i++) begin
      h.wr(t[i][0], t[i][1]);
      rchk(t[i][0], t[i][2]);
    end
    chk("ext", 12'h001, {11'h0, ext});
    chk("instant", 12'h001, {11'h0, ri});
    chk("spread", 12'h001, {11'h0, se});
    chk("mod khz", 12'h00a, mk);
    chk("linreg1 mv", 12'hdac, l1m);
    chk("linreg2 mv", 12'hdac, l2m);
    h.wr(8'h2a, 8'h0d);
    settle();
    chk("ext", 12'h000, {11'h0, ext});
    chk("conv2 mv", 12'h898, cmv);
    h.wr(8'h2a, 8'h0e);
    settle();
    chk("conv2 mv", 12'h960, cmv);
    h.wr(8'h2a, 8'h01);
    settle();
    chk("conv2 mv", 12'h3e8, cmv);
    h.wr(8'h2a, 8'h1c);
    settle();
    chk("conv2 mv", 12'hdac, cmv);
    chk("conv2 code", 12'h01c, {7'h0, cc});
    h.wr(8'h2b, 8'h0c);
    settle();
    chk("ramp rate", 12'h00a, {8'h0, rm});
    chk("instant", 12'h000, {11'h0, ri});
    h.wr(8'h2b, 8'h05);
    settle();
    chk("ramp rate", 12'h005, {8'h0, rm});
    chk("ramp code", 12'h005, {8'h0, rc});
    h.wr(8'h38, 8'h02);
    settle();
    chk("spread", 12'h000, {11'h0, se});
    chk("mod sel", 12'h001, {11'h0, ss});
    chk("mod khz", 12'h002, mk);
    chk("center khz", 12'h7d0, ck);
    h.wr(8'h39, 8'h00);
    settle();
    chk("linreg1 mv", 12'h3e8, l1m);
    chk("linreg1 code", 12'h000, {7'h0, l1c});
    h.wr(8'h3a, 8'h19);
    settle();
    chk("linreg2 mv", 12'hdac, l2m);
    chk("linreg2 code", 12'h019, {7'h0, l2c});
    conclude();
  end
endmodule
